// ---- core/tpm_pkg.sv ----
// Package: constants and carriers for the thermal protection monitor
package tpm_pkg;
    // ------------------------------------------------------------
    // Register indices (byte address is four times the index)
    // ------------------------------------------------------------
    localparam int ADR_W = 10;
    localparam logic [7:0] IDX_PWR_STATUS = 8'h01;
    localparam logic [7:0] IDX_IRQ_EN = 8'h43;
    localparam logic [7:0] IDX_CODE_HI = 8'h58;
    localparam logic [7:0] IDX_CODE_LO = 8'h59;
    localparam logic [7:0] IDX_ADC_EN = 8'h82;
    localparam logic [7:0] IDX_BIAS = 8'h84;
    localparam logic [7:0] IDX_SHDN = 8'h8f;
    localparam logic [7:0] IDX_UT1 = 8'h38;
    localparam logic [7:0] IDX_OT1 = 8'h39;
    localparam logic [7:0] IDX_UT2 = 8'h3c;
    localparam logic [7:0] IDX_OT2 = 8'h3d;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int F_DIE_OT = 7;
    localparam int F_BATT_OK = 6;
    localparam int F_IRQ_DIE_OT = 7;
    localparam int F_TS_ADC_EN = 0;
    localparam int F_BIAS_MAG = 4;
    localparam int F_PIN_FUNC = 2;
    localparam int F_BIAS_GATE = 0;
    localparam int F_SHDN_L3 = 2;
    localparam int F_CODE_HI = 4;

    // ------------------------------------------------------------
    // Modes and carriers
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        GATE_OFF = 2'h0,
        GATE_CHG = 2'h1,
        GATE_ADC = 2'h2,
        GATE_ON = 2'h3
    } tpm_gate_t;

    typedef struct packed {
        logic irqEnDieOt;
        logic tsAdcEn;
        logic [1:0] biasMag;
        logic pinFunc;
        tpm_gate_t biasGate;
        logic shdnEnL3;
    } tpm_cfg_t;

    localparam tpm_cfg_t CFG_RST = '{
        irqEnDieOt: 1'b0, tsAdcEn: 1'b0, biasMag: 2'h3,
        pinFunc: 1'b0, biasGate: GATE_ADC, shdnEnL3: 1'b0};

    localparam logic [7:0] RST_UT1 = 8'ha5;
    localparam logic [7:0] RST_OT1 = 8'h1e;
    localparam logic [7:0] RST_UT2 = 8'hfb;
    localparam logic [7:0] RST_OT2 = 8'h16;

    // ------------------------------------------------------------
    // Hysteresis and level spacing
    // ------------------------------------------------------------
    localparam int ADC_LSB_DMV = 8;
    localparam int HYST_UT_DMV = 4608;
    localparam int HYST_OT_DMV = 576;
    localparam int HYST_UT_CODES = HYST_UT_DMV / ADC_LSB_DMV;
    localparam int HYST_OT_CODES = HYST_OT_DMV / ADC_LSB_DMV;
    localparam int DIE_LSB_MC = 106;
    localparam int DIE_STEP_MC = 6800;
    localparam int DIE_HYST_MC = 13600;
    localparam int DIE_STEP_CODES = DIE_STEP_MC / DIE_LSB_MC;
    localparam int DIE_HYST_CODES = DIE_HYST_MC / DIE_LSB_MC;
endpackage : tpm_pkg

// ---- core/tpm_hyst_cmp.sv ----
// Threshold comparator with hysteresis, evaluated per sample
`timescale 1ns/1ps
`default_nettype none
module tpm_hyst_cmp
    import tpm_pkg::*;
#(
    parameter int W = 12
) (
    input wire logic ref_clk,
    input wire logic resetn,
    input wire logic sample,
    input wire logic clear,
    input wire logic upDir,
    input wire logic [W-1:0] value,
    input wire logic signed [W+1:0] setLvl,
    input wire logic signed [W+1:0] clrLvl,
    output logic active,
    output logic setPulse,
    output logic clrPulse
);
    logic active_ff;
    logic setPulse_ff;
    logic clrPulse_ff;
    logic signed [W+1:0] valS;
    logic trip;
    logic rel;

    assign valS = $signed({2'b00, value});
    assign trip = upDir ? (valS > setLvl) : (valS < setLvl);
    assign rel = upDir ? (valS < clrLvl) : (valS > clrLvl);

    // ------------------------------------------------------------
    // State and edge pulses
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            active_ff <= 1'b0;
        end else if (clear) begin
            active_ff <= 1'b0;
        end else if (sample && !active_ff && trip) begin
            active_ff <= 1'b1;
        end else if (sample && active_ff && rel) begin
            active_ff <= 1'b0;
        end
    end

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            setPulse_ff <= 1'b0;
            clrPulse_ff <= 1'b0;
        end else begin
            setPulse_ff <= !clear && sample && !active_ff && trip;
            clrPulse_ff <= !clear && sample && active_ff && rel;
        end
    end

    assign active = active_ff;
    assign setPulse = setPulse_ff;
    assign clrPulse = clrPulse_ff;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    property p_cmp_set;
        @(posedge ref_clk) disable iff (!resetn)
        sample && !clear && !active && trip |=> active && setPulse;
    endproperty
    a_cmp_set: assert property (p_cmp_set) else $error("trip not taken");

    property p_cmp_hold;
        @(posedge ref_clk) disable iff (!resetn)
        !sample && !clear |=> $stable(active) && !setPulse && !clrPulse;
    endproperty
    a_cmp_hold: assert property (p_cmp_hold) else $error("moved without sample");
endmodule : tpm_hyst_cmp
`default_nettype wire

// ---- core/tpm_monitor.sv ----
// Thermal protection monitor: die levels, thermistor bias and battery limits
`timescale 1ns/1ps
`default_nettype none
module tpm_monitor
    import tpm_pkg::*;
#(
    parameter int CODE_W = 12,
    parameter int DIE_L1_CODE = 2900
) (
    input wire logic ref_clk,
    input wire logic resetn,
    input wire logic wbCyc,
    input wire logic wbStb,
    input wire logic wbWe,
    input wire logic [ADR_W-1:0] wbAdr,
    input wire logic [3:0] wbSel,
    input wire logic [31:0] wbDatI,
    output logic [31:0] wbDatO,
    output logic wbAck,
    input wire logic [CODE_W-1:0] dieCode,
    input wire logic dieValid,
    input wire logic [CODE_W-1:0] tsCode,
    input wire logic tsValid,
    input wire logic charging,
    input wire logic adcPhase,
    output logic biasOn,
    output logic [1:0] biasMag,
    output logic tsToAdc,
    output logic gpadcBlocked,
    output logic chargeThrottle,
    output logic chargeStop,
    output logic shutdownReq,
    output logic dieOtIrq,
    output logic battIrq
);
    localparam int LW = CODE_W + 2;

    tpm_cfg_t cfg_ff;
    logic [7:0] thr_ff [4];
    logic [CODE_W-1:0] tsCode_ff;
    logic ack_ff;
    logic [31:0] wbDatO_ff;
    logic throttle_ff;
    logic stop_ff;
    logic shdn_ff;
    logic dieIrq_ff;
    logic battIrq_ff;
    logic req;
    logic wrEn;
    logic [7:0] idx;
    logic [7:0] rdByte;
    logic [2:0] dieLvl;
    logic [2:0] dieSetP;
    logic [3:0] batAct;
    logic [3:0] batSetP;
    logic [3:0] batClrP;
    logic battEval;
    logic irqAllowed;
    logic battEvent;
    logic battFault1;

    // ------------------------------------------------------------
    // Wishbone slave
    // ------------------------------------------------------------
    assign req = wbCyc && wbStb && !ack_ff;
    assign wrEn = req && wbWe && wbSel[0];
    assign idx = wbAdr[ADR_W-1:2];

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            ack_ff <= 1'b0;
        end else begin
            ack_ff <= req;
        end
    end

    always_comb begin
        rdByte = 8'h00;
        case (idx)
            IDX_PWR_STATUS: begin
                rdByte[F_DIE_OT] = dieLvl[1];
                rdByte[F_BATT_OK] = !battFault1;
            end
            IDX_IRQ_EN: rdByte[F_IRQ_DIE_OT] = cfg_ff.irqEnDieOt;
            IDX_CODE_HI: rdByte = tsCode_ff[CODE_W-1:F_CODE_HI];
            IDX_CODE_LO: rdByte[F_CODE_HI-1:0] = tsCode_ff[F_CODE_HI-1:0];
            IDX_ADC_EN: rdByte[F_TS_ADC_EN] = cfg_ff.tsAdcEn;
            IDX_BIAS: begin
                rdByte[F_BIAS_MAG+:2] = cfg_ff.biasMag;
                rdByte[F_PIN_FUNC] = cfg_ff.pinFunc;
                rdByte[F_BIAS_GATE+:2] = cfg_ff.biasGate;
            end
            IDX_SHDN: rdByte[F_SHDN_L3] = cfg_ff.shdnEnL3;
            IDX_UT1: rdByte = thr_ff[0];
            IDX_OT1: rdByte = thr_ff[1];
            IDX_UT2: rdByte = thr_ff[2];
            IDX_OT2: rdByte = thr_ff[3];
            default: rdByte = 8'h00;
        endcase
    end

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            wbDatO_ff <= 32'h0000_0000;
        end else if (req && !wbWe) begin
            wbDatO_ff <= {24'h00_0000, rdByte};
        end
    end

    assign wbAck = ack_ff;
    assign wbDatO = wbDatO_ff;

    // ------------------------------------------------------------
    // Configuration registers
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            cfg_ff <= CFG_RST;
        end else if (wrEn) begin
            case (idx)
                IDX_IRQ_EN: cfg_ff.irqEnDieOt <= wbDatI[F_IRQ_DIE_OT];
                IDX_ADC_EN: cfg_ff.tsAdcEn <= wbDatI[F_TS_ADC_EN];
                IDX_BIAS: begin
                    cfg_ff.biasMag <= wbDatI[F_BIAS_MAG+:2];
                    cfg_ff.pinFunc <= wbDatI[F_PIN_FUNC];
                    cfg_ff.biasGate <= tpm_gate_t'(wbDatI[F_BIAS_GATE+:2]);
                end
                IDX_SHDN: cfg_ff.shdnEnL3 <= wbDatI[F_SHDN_L3];
                default: cfg_ff <= cfg_ff;
            endcase
        end
    end

    // Battery thresholds, upper eight code bits
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            thr_ff[0] <= RST_UT1;
            thr_ff[1] <= RST_OT1;
            thr_ff[2] <= RST_UT2;
            thr_ff[3] <= RST_OT2;
        end else if (wrEn) begin
            case (idx)
                IDX_UT1: thr_ff[0] <= wbDatI[7:0];
                IDX_OT1: thr_ff[1] <= wbDatI[7:0];
                IDX_UT2: thr_ff[2] <= wbDatI[7:0];
                IDX_OT2: thr_ff[3] <= wbDatI[7:0];
                default: thr_ff[0] <= thr_ff[0];
            endcase
        end
    end

    // ------------------------------------------------------------
    // Thermistor bias and conversion capture
    // ------------------------------------------------------------
    always_comb begin
        unique case (cfg_ff.biasGate)
            GATE_OFF: biasOn = 1'b0;
            GATE_CHG: biasOn = charging;
            GATE_ADC: biasOn = adcPhase;
            GATE_ON: biasOn = 1'b1;
        endcase
    end

    assign biasMag = cfg_ff.biasMag;
    assign gpadcBlocked = cfg_ff.biasGate == GATE_ON;
    assign tsToAdc = cfg_ff.tsAdcEn && !cfg_ff.pinFunc;

    // Code arrives already scaled at 0.8 mV per step
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            tsCode_ff <= '0;
        end else if (tsValid && tsToAdc) begin
            tsCode_ff <= tsCode;
        end
    end

    // ------------------------------------------------------------
    // Die temperature levels
    // ------------------------------------------------------------
    for (genvar g = 0; g < 3; g++) begin : g_die
        localparam int SET = DIE_L1_CODE + g * DIE_STEP_CODES;
        tpm_hyst_cmp #(.W(CODE_W)) u_cmp (
            .ref_clk(ref_clk),
            .resetn(resetn),
            .sample(dieValid),
            .clear(1'b0),
            .upDir(1'b1),
            .value(dieCode),
            .setLvl(LW'(SET)),
            .clrLvl(LW'(SET - DIE_HYST_CODES)),
            .active(dieLvl[g]),
            .setPulse(dieSetP[g]),
            .clrPulse()
        );
    end

    // ------------------------------------------------------------
    // Battery thresholds: 0 UT1, 1 OT1, 2 UT2, 3 OT2
    // ------------------------------------------------------------
    assign battEval = cfg_ff.tsAdcEn && !cfg_ff.pinFunc;

    for (genvar b = 0; b < 4; b++) begin : g_bat
        localparam bit UNDER = (b % 2) == 0;
        logic signed [LW-1:0] setL;
        logic signed [LW-1:0] clrL;
        assign setL = $signed({2'b00, thr_ff[b], 4'h0});
        assign clrL = UNDER ? setL - LW'(HYST_UT_CODES)
                            : setL + LW'(HYST_OT_CODES);
        tpm_hyst_cmp #(.W(CODE_W)) u_cmp (
            .ref_clk(ref_clk),
            .resetn(resetn),
            .sample(tsValid && battEval),
            .clear(cfg_ff.pinFunc),
            .upDir(UNDER),
            .value(tsCode),
            .setLvl(setL),
            .clrLvl(clrL),
            .active(batAct[b]),
            .setPulse(batSetP[b]),
            .clrPulse(batClrP[b])
        );
    end

    assign battFault1 = batAct[0] || batAct[1];

    always_comb begin
        unique case (cfg_ff.biasGate)
            GATE_OFF: irqAllowed = 1'b0;
            GATE_CHG: irqAllowed = charging;
            GATE_ADC, GATE_ON: irqAllowed = 1'b1;
        endcase
    end

    assign battEvent = |batSetP || batClrP[0] || batClrP[1];

    // ------------------------------------------------------------
    // Charger, shutdown and event outputs
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            throttle_ff <= 1'b0;
            stop_ff <= 1'b0;
            shdn_ff <= 1'b0;
        end else begin
            throttle_ff <= |dieLvl;
            stop_ff <= battFault1;
            shdn_ff <= dieLvl[2] && cfg_ff.shdnEnL3;
        end
    end

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            dieIrq_ff <= 1'b0;
            battIrq_ff <= 1'b0;
        end else begin
            dieIrq_ff <= dieSetP[1] && cfg_ff.irqEnDieOt;
            battIrq_ff <= battEvent && battEval && irqAllowed;
        end
    end

    assign chargeThrottle = throttle_ff;
    assign chargeStop = stop_ff;
    assign shutdownReq = shdn_ff;
    assign dieOtIrq = dieIrq_ff;
    assign battIrq = battIrq_ff;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!resetn);

    sequence s_l2_rise;
        dieSetP[1] && cfg_ff.irqEnDieOt;
    endsequence

    property p_throttle;
        dieLvl[0] |=> chargeThrottle;
    endproperty
    a_throttle: assert property (p_throttle) else $error("no throttle");

    property p_resume;
        !dieLvl[0] [*2] |=> !chargeThrottle;
    endproperty
    a_resume: assert property (p_resume) else $error("throttle stuck");

    property p_die_irq;
        s_l2_rise |=> dieOtIrq ##1 !dieOtIrq;
    endproperty
    a_die_irq: assert property (p_die_irq) else $error("die irq wrong");

    property p_die_irq_en;
        dieOtIrq |-> $past(cfg_ff.irqEnDieOt) && $past(dieLvl[1]);
    endproperty
    a_die_irq_en: assert property (p_die_irq_en) else $error("die irq unmasked");

    property p_shutdown;
        $rose(shutdownReq) |-> $past(dieLvl[2]) && $past(cfg_ff.shdnEnL3);
    endproperty
    a_shutdown: assert property (p_shutdown) else $error("bad shutdown");

    property p_bias_off;
        cfg_ff.biasGate == GATE_OFF |-> !biasOn;
    endproperty
    a_bias_off: assert property (p_bias_off) else $error("bias on when off");

    property p_batt_stop;
        battFault1 |=> chargeStop;
    endproperty
    a_batt_stop: assert property (p_batt_stop) else $error("no charge stop");

    property p_general_analog_input_mode_quiet;
        $past(cfg_ff.pinFunc) |-> !battIrq;
    endproperty
    a_general_analog_input_mode_quiet: assert property (p_general_analog_input_mode_quiet) else $error("irq in general_analog_input_mode mode");

    property p_wb_ack;
        wbCyc && wbStb && !wbAck |=> wbAck ##1 !wbAck;
    endproperty
    a_wb_ack: assert property (p_wb_ack) else $error("ack timing wrong");
endmodule : tpm_monitor
`default_nettype wire

// ---- tb/tpm_sensor_model.sv ----
// Sensor-side model: die temperature samples and thermistor conversions
`timescale 1ns/1ps
`default_nettype none
module tpm_sensor_model (
    input wire logic ref_clk,
    input wire logic resetn,
    input wire logic dieReq,
    input wire logic [11:0] dieReqCode,
    input wire logic tsReq,
    input wire logic [31:0] tsOhms,
    input wire logic biasOn,
    input wire logic [1:0] biasMag,
    output logic [11:0] dieCode,
    output logic dieValid,
    output logic [11:0] tsCode,
    output logic tsValid
);
    logic [31:0] conv;
    // No bias current gives no voltage across the thermistor
    always_comb begin
        conv = 32'h0000_0000;
        if (biasOn)
            conv = tsOhms * (32'h0000_0014 * ({30'h0, biasMag} + 32'h0000_0001)) / 32'h0000_0320;
    end
    // Codes are only meaningful while valid; otherwise they toggle
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            dieValid <= 1'b0;
            dieCode <= 12'h000;
            tsValid <= 1'b0;
            tsCode <= 12'h000;
        end else begin
            dieValid <= dieReq;
            dieCode <= dieReq ? dieReqCode : ~dieCode;
            tsValid <= tsReq;
            if (tsReq)
                tsCode <= (conv > 32'h0000_0fff) ? 12'hfff : conv[11:0];
            else
                tsCode <= ~tsCode;
        end
    end
endmodule : tpm_sensor_model
`default_nettype wire

// ---- tb/tb_thermal_protection_monitor.sv ----
// Self-checking bench for the thermal protection monitor
`timescale 1ns/1ps
`default_nettype none
module tb_thermal_protection_monitor import tpm_pkg::*; ();
    localparam int L1 = 2000;
    logic ref_clk, resetn, wbCyc, wbStb, wbWe, wbAck, charging, adcPhase;
    logic [ADR_W-1:0] wbAdr;
    logic [3:0] wbSel;
    logic [31:0] wbDatI, wbDatO, tsOhms, lfsr;
    logic biasOn, tsToAdc, gpadcBlocked, chargeThrottle, chargeStop, shutdownReq;
    logic dieOtIrq, battIrq, dieValid, tsValid, dieReq, tsReq;
    logic [1:0] biasMag;
    logic [11:0] dieCode, tsCode, dieReqCode;
    logic [7:0] rd;
    int fails, samples_checked, cycles, dieIrqs, battIrqs;
    int thr[4], act[4], dl[3];
    int mag, gate, pin, tsEn, codeReg, dieIrqEn, shdnEn;
    logic [7:0] rIdx[12] = '{8'h01, 8'h43, 8'h82, 8'h84, 8'h8f, 8'h38,
                             8'h39, 8'h3c, 8'h3d, 8'h58, 8'h59, 8'h10};
    logic [7:0] rExp[12] = '{8'h40, 8'h00, 8'h00, 8'h32, 8'h00, 8'ha5,
                             8'h1e, 8'hfb, 8'h16, 8'h00, 8'h00, 8'h00};

    tpm_monitor #(.CODE_W(12), .DIE_L1_CODE(L1)) uut (.ref_clk(ref_clk), .resetn(resetn),
        .wbCyc(wbCyc), .wbStb(wbStb), .wbWe(wbWe), .wbAdr(wbAdr), .wbSel(wbSel),
        .wbDatI(wbDatI), .wbDatO(wbDatO), .wbAck(wbAck), .dieCode(dieCode),
        .dieValid(dieValid), .tsCode(tsCode), .tsValid(tsValid), .charging(charging),
        .adcPhase(adcPhase), .biasOn(biasOn), .biasMag(biasMag), .tsToAdc(tsToAdc),
        .gpadcBlocked(gpadcBlocked), .chargeThrottle(chargeThrottle),
        .chargeStop(chargeStop), .shutdownReq(shutdownReq), .dieOtIrq(dieOtIrq),
        .battIrq(battIrq));
    tpm_sensor_model model (.ref_clk(ref_clk), .resetn(resetn), .dieReq(dieReq),
        .dieReqCode(dieReqCode), .tsReq(tsReq), .tsOhms(tsOhms), .biasOn(biasOn),
        .biasMag(biasMag), .dieCode(dieCode), .dieValid(dieValid), .tsCode(tsCode),
        .tsValid(tsValid));

    initial begin
        ref_clk = 1'b0;
        forever #4 ref_clk = ~ref_clk;
    end

    // ------------------------------------------------------------
    // Checking and bus tasks
    // ------------------------------------------------------------
    task automatic complete_run;
        $display("checks %0d mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : complete_run

    always @(posedge ref_clk) begin
        cycles++;
        if (dieOtIrq === 1'b1) dieIrqs++;
        if (battIrq === 1'b1) battIrqs++;
        if (cycles == 20000) begin
            fails++;
            $display("MISMATCH %0t run timed out", $time);
            complete_run();
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        samples_checked++;
        if (got !== exp) begin
            fails++;
            $display("MISMATCH %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask : chk

    function automatic logic [31:0] nextRand(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : nextRand

    task automatic wbXfer(input logic we, input logic [7:0] idx, input logic [7:0] d);
        @(posedge ref_clk);
        wbCyc <= 1'b1;
        wbStb <= 1'b1;
        wbWe <= we;
        wbAdr <= {idx, 2'b00};
        wbDatI <= {24'h00_0000, d};
        // Only the bench timeout ends a wait for the answer
        do begin
            @(posedge ref_clk);
        end while (wbAck !== 1'b1);
        rd = wbDatO[7:0];
        wbCyc <= 1'b0;
        wbStb <= 1'b0;
    endtask : wbXfer

    task automatic setBias(input int m, input int p, input int g);
        mag = m;
        pin = p;
        gate = g;
        wbXfer(1'b1, 8'h84, {2'b00, m[1:0], 1'b0, p[0], g[1:0]});
    endtask : setBias

    task automatic dieSend(input int code);
        int base, prev, lvl;
        base = dieIrqs;
        prev = dl[1];
        @(posedge ref_clk);
        dieReq <= 1'b1;
        dieReqCode <= code[11:0];
        @(posedge ref_clk);
        dieReq <= 1'b0;
        repeat (5) @(posedge ref_clk);
        for (int k = 0; k < 3; k++) begin
            lvl = L1 + k * DIE_STEP_CODES;
            if (code > lvl) dl[k] = 1;
            else if (code < lvl - DIE_HYST_CODES) dl[k] = 0;
        end
        chk(chargeThrottle, dl[0] | dl[1] | dl[2], "throttle");
        chk(shutdownReq, dl[2] & shdnEn, "shutdown");
        chk(dieIrqs - base, dl[1] > prev && dieIrqEn, "die irq");
        wbXfer(1'b0, 8'h01, 8'h00);
        chk(rd[7], dl[1], "die status");
    endtask : dieSend

    task automatic tsStep(input int ohms, input int m, input int g, input int c, input int p);
        int code, base, evt, prev, t;
        setBias(m, p, g);
        charging <= c[0];
        base = battIrqs;
        @(posedge ref_clk);
        tsReq <= 1'b1;
        tsOhms <= ohms;
        @(posedge ref_clk);
        tsReq <= 1'b0;
        repeat (5) @(posedge ref_clk);
        code = (g >= 2 || (g == 1 && c == 1)) ? ohms * 20 * (m + 1) / 800 : 0;
        if (code > 4095) code = 4095;
        evt = 0;
        if (p) act = '{0, 0, 0, 0};
        else if (tsEn) begin
            codeReg = code;
            for (int i = 0; i < 4; i++) begin
                prev = act[i];
                t = thr[i] * 16;
                if (i % 2 == 0) begin
                    if (code > t) act[i] = 1;
                    else if (code < t - HYST_UT_CODES) act[i] = 0;
                end else begin
                    if (code < t) act[i] = 1;
                    else if (code > t + HYST_OT_CODES) act[i] = 0;
                end
                if (act[i] > prev || (act[i] < prev && i < 2)) evt = 1;
            end
        end
        if (g == 0 || (g == 1 && c == 0)) evt = 0;
        chk(chargeStop, act[0] | act[1], "charge stop");
        chk(battIrqs - base, evt, "batt irq");
        wbXfer(1'b0, 8'h01, 8'h00);
        chk(rd[6], !(act[0] | act[1]), "batt normal");
        wbXfer(1'b0, 8'h58, 8'h00);
        chk(rd, codeReg >> 4, "code high");
        wbXfer(1'b0, 8'h59, 8'h00);
        chk(rd, codeReg & 15, "code low");
    endtask : tsStep

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        fails = 0; samples_checked = 0; cycles = 0; dieIrqs = 0; battIrqs = 0;
        resetn = 1'b0; wbCyc = 1'b0; wbStb = 1'b0; wbWe = 1'b0; wbAdr = '0;
        wbSel = 4'hf; wbDatI = '0; charging = 1'b0; adcPhase = 1'b0;
        dieReq = 1'b0; tsReq = 1'b0; dieReqCode = '0; tsOhms = '0;
        lfsr = 32'h6239_e119; thr = '{165, 30, 251, 22}; act = '{0, 0, 0, 0};
        dl = '{0, 0, 0}; tsEn = 0; codeReg = 0; dieIrqEn = 0; shdnEn = 0;
        repeat (8) @(posedge ref_clk);
        resetn <= 1'b1;
        for (int i = 0; i < 12; i++) begin
            wbXfer(1'b0, rIdx[i], 8'h00);
            chk(rd, rExp[i], "reset value");
        end
        wbXfer(1'b1, 8'h01, 8'hff);
        wbXfer(1'b0, 8'h01, 8'h00);
        chk(rd, 8'h40, "read-only status");
        for (int i = 0; i < 8; i++) begin
            lfsr = nextRand(lfsr);
            setBias(lfsr[1:0], 0, i % 4);
            charging <= lfsr[4];
            adcPhase <= lfsr[5];
            repeat (2) @(posedge ref_clk);
            chk(biasMag, mag, "bias magnitude");
            chk(biasOn, gate == 3 || (gate == 1 && lfsr[4]) || (gate == 2 && lfsr[5]), "bias");
            chk(gpadcBlocked, gate == 3, "shared input");
        end
        wbXfer(1'b1, 8'h43, 8'h80); dieIrqEn = 1;
        wbXfer(1'b1, 8'h8f, 8'h04); shdnEn = 1;
        dieSend(L1 + 1);
        dieSend(L1 + DIE_STEP_CODES);
        dieSend(L1 - 100);
        dieSend(L1 + 65);
        dieSend(L1 + 129);
        dieSend(L1 - 65);
        dieSend(L1 - 129);
        wbXfer(1'b1, 8'h43, 8'h00); dieIrqEn = 0;
        dieSend(L1 + 65);
        dieSend(L1 - 129);
        adcPhase <= 1'b1;
        wbXfer(1'b1, 8'h82, 8'h01); tsEn = 1;
        wbXfer(1'b1, 8'h38, 8'ha0); thr[0] = 160;
        setBias(3, 0, 2);
        chk(tsToAdc, 1'b1, "route");
        tsStep(27000, 3, 2, 0, 0);
        tsStep(22000, 3, 2, 0, 0);
        tsStep(20000, 3, 2, 0, 0);
        tsStep(4500, 3, 3, 0, 0);
        tsStep(5400, 3, 3, 0, 0);
        tsStep(5600, 3, 3, 0, 0);
        tsStep(41000, 3, 2, 0, 0);
        tsStep(20000, 3, 2, 0, 0);
        tsStep(27000, 0, 2, 0, 0);
        tsStep(27000, 3, 0, 0, 0);
        tsStep(20000, 3, 1, 0, 0);
        tsStep(20000, 3, 1, 1, 0);
        tsStep(27000, 3, 2, 0, 1);
        setBias(3, 0, 2);
        chk(tsToAdc, 1'b1, "route back");
        wbXfer(1'b1, 8'h82, 8'h00); tsEn = 0;
        chk(tsToAdc, 1'b0, "route off");
        tsStep(27000, 3, 2, 0, 0);
        complete_run();
    end
endmodule : tb_thermal_protection_monitor
`default_nettype wire
